// ### sif_defines.svh
`ifndef SIF_DEFINES_SVH
`define SIF_DEFINES_SVH

// ==========================================================
// Bus framing
`define SIF_ADDR 7'h62
`define SIF_CMD_REINIT 16'h3646
`define SIF_CRC_POLY 8'h31
`define SIF_CRC_INIT 8'hFF
`define SIF_SCL_MAX_KHZ 100

// ==========================================================
// Timing
`define SIF_CLK_MHZ 250
`define SIF_PWRUP_MS 1000
`define SIF_READY_CYC (`SIF_PWRUP_MS * `SIF_CLK_MHZ * 1000)

`endif

// ### sif_pkg.sv
`default_nettype none
`include "sif_defines.svh"

package sif_pkg;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_WR = 3'b011,
    ST_RD = 3'b100,
    ST_RACK = 3'b101,
    ST_SKIP = 3'b110
  } sif_st_e;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_q;
    logic sda_s1;
    logic sda_s2;
    logic sda_q;
    sif_st_e st;
    logic [3:0] bc;
    logic [7:0] sh;
    logic rw;
    logic nack;
    logic [2:0] bpos;
    logic [1:0] rpos;
    logic [7:0] hi;
    logic [15:0] word;
    logic [7:0] tx;
    logic [15:0] rd_word;
    logic oe;
    logic sda_o;
    logic cmd_valid;
    logic [15:0] cmd_code;
    logic wr_valid;
    logic [15:0] wr_word;
    logic crc_err;
    logic rd_take;
    logic rdy;
    logic restart;
  } sif_st_s;

  typedef struct packed {
    logic [27:0] cnt;
    logic ready;
  } sif_tmr_s;

  // ==========================================================
  // Checksum over one word, high byte first
  function automatic logic [7:0] sif_crc8(input logic [15:0] w);
    logic [7:0] c;
    c = `SIF_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ `SIF_CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

endpackage

`default_nettype wire

// ### sif_ctl_if.sv
`timescale 1ns/1ns
`default_nettype none

interface sif_ctl_if;
  logic restart;
  logic ready;
  modport main (output restart, input ready);
  modport timer (input restart, output ready);
endinterface

`default_nettype wire

// ### sif_ready_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "sif_defines.svh"

module sif_ready_timer import sif_pkg::*; #(
  parameter logic [27:0] READY_CYC = 28'(`SIF_READY_CYC)
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  sif_ctl_if.timer ctl
);

  sif_tmr_s s, n;

  // ==========================================================
  // Start-up and reinit delay
  always_comb begin
    n = s;
    if (ctl.restart) begin
      n.cnt = '0;
      n.ready = 1'b0;
    end else if (!s.ready) begin
      if (s.cnt == READY_CYC - 28'd1) begin
        n.ready = 1'b1;
      end else begin
        n.cnt = s.cnt + 28'd1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign ctl.ready = s.ready;

  // ==========================================================
  // Checks
  a_ready_after_count: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(s.ready) |-> $past(s.cnt) == READY_CYC - 28'd1)
    else $error("ready rose before the full delay");
  a_restart_drops_ready: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ctl.restart |=> !s.ready && s.cnt == '0)
    else $error("restart did not drop ready");

endmodule

`default_nettype wire

// ### sif_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sif_defines.svh"


module sif_top import sif_pkg::*; #(
  parameter logic [27:0] READY_CYC = 28'(`SIF_READY_CYC)
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic [15:0] i_rd_word,
  output logic o_rd_take,
  output logic o_cmd_valid,
  output logic [15:0] o_cmd_code,
  output logic o_wr_valid,
  output logic [15:0] o_wr_word,
  output logic o_crc_err,
  output logic o_ready
);

  // ==========================================================
  // Reset release
  logic [1:0] rst_q;
  logic rst_n;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ==========================================================
  // Ready timer
  sif_ctl_if ctl ();

  sif_ready_timer #(.READY_CYC(READY_CYC)) u_tmr (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n),
    .ctl(ctl)
  );

  // ==========================================================
  // Bus engine
  sif_st_s s, n;
  logic rise, fall, start, stop;
  logic [7:0] ld_byte;

  // Lines sampled at 250 MHz; 100 kHz leaves ample margin
  assign rise = s.scl_s2 & ~s.scl_q;
  assign fall = ~s.scl_s2 & s.scl_q;
  assign start = s.scl_s2 & s.scl_q & s.sda_q & ~s.sda_s2;
  assign stop = s.scl_s2 & s.scl_q & ~s.sda_q & s.sda_s2;

  always_comb begin
    n = s;
    n.scl_s1 = i_scl;
    n.scl_s2 = s.scl_s1;
    n.scl_q = s.scl_s2;
    n.sda_s1 = i_sda;
    n.sda_s2 = s.sda_s1;
    n.sda_q = s.sda_s2;
    n.sda_o = 1'b0;
    n.cmd_valid = 1'b0;
    n.wr_valid = 1'b0;
    n.rd_take = 1'b0;
    n.restart = 1'b0;
    n.rdy = ctl.ready;
    // Next read byte: high, low, checksum, then a fresh word
    unique case (s.rpos)
      2'd0: ld_byte = i_rd_word[15:8];
      2'd1: ld_byte = s.rd_word[7:0];
      default: ld_byte = sif_crc8(s.rd_word);
    endcase
    if (start) begin
      n.st = ST_ADDR;
      n.bc = 4'h0;
      n.oe = 1'b0;
      n.bpos = 3'd0;
      n.rpos = 2'd0;
    end else if (stop) begin
      n.st = ST_IDLE;
      n.oe = 1'b0;
    end else begin
      unique case (s.st)
        ST_IDLE, ST_SKIP: begin
          n.oe = 1'b0;
        end
        ST_ADDR, ST_WR: begin
          if (rise) begin
            n.sh = {s.sh[6:0], s.sda_s2};
            n.bc = s.bc + 4'h1;
          end else if (fall && s.bc == 4'h8) begin
            n.bc = 4'h0;
            if (!s.rdy) begin
              n.st = ST_SKIP;
            end else if (s.st == ST_ADDR) begin
              if (s.sh[7:1] == `SIF_ADDR) begin
                n.oe = 1'b1;
                n.rw = s.sh[0];
                n.st = ST_ACK;
              end else begin
                n.st = ST_SKIP;
              end
            end else begin
              n.oe = 1'b1;
              n.st = ST_ACK;
              unique case (s.bpos)
                3'd0: begin
                  n.hi = s.sh;
                  n.bpos = 3'd1;
                end
                3'd1: begin
                  n.cmd_code = {s.hi, s.sh};
                  n.cmd_valid = 1'b1;
                  n.restart = ({s.hi, s.sh} == `SIF_CMD_REINIT);
                  n.bpos = 3'd2;
                end
                3'd2: begin
                  n.hi = s.sh;
                  n.bpos = 3'd3;
                end
                3'd3: begin
                  n.word = {s.hi, s.sh};
                  n.bpos = 3'd4;
                end
                default: begin
                  n.wr_word = s.word;
                  n.wr_valid = 1'b1;
                  n.crc_err = (sif_crc8(s.word) != s.sh);
                  n.bpos = 3'd2;
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (fall) begin
            n.bc = 4'h0;
            if (s.rw) begin
              n.st = ST_RD;
              n.tx = ld_byte;
              n.oe = ~ld_byte[7];
              n.rpos = (s.rpos == 2'd2) ? 2'd0 : s.rpos + 2'd1;
              if (s.rpos == 2'd0) begin
                n.rd_word = i_rd_word;
                n.rd_take = 1'b1;
              end
            end else begin
              n.oe = 1'b0;
              n.st = ST_WR;
            end
          end
        end
        ST_RD: begin
          if (rise) begin
            n.bc = s.bc + 4'h1;
          end else if (fall) begin
            if (s.bc == 4'h8) begin
              n.oe = 1'b0;
              n.bc = 4'h0;
              n.st = ST_RACK;
            end else begin
              n.tx = {s.tx[6:0], 1'b0};
              n.oe = ~s.tx[6];
            end
          end
        end
        ST_RACK: begin
          if (rise) begin
            n.nack = s.sda_s2;
          end else if (fall) begin
            if (s.nack) begin
              n.st = ST_SKIP;
            end else begin
              n.st = ST_RD;
              n.tx = ld_byte;
              n.oe = ~ld_byte[7];
              n.rpos = (s.rpos == 2'd2) ? 2'd0 : s.rpos + 2'd1;
              if (s.rpos == 2'd0) begin
                n.rd_word = i_rd_word;
                n.rd_take = 1'b1;
              end
            end
          end
        end
        default: begin
          n.st = ST_IDLE;
          n.oe = 1'b0;
        end
      endcase
    end
  end

  // Lines reset high so no false START after release
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.scl_s1 <= 1'b1;
      s.scl_s2 <= 1'b1;
      s.scl_q <= 1'b1;
      s.sda_s1 <= 1'b1;
      s.sda_s2 <= 1'b1;
      s.sda_q <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign ctl.restart = s.restart;
  assign o_sda_o = s.sda_o;
  assign o_sda_oe = s.oe;
  assign o_rd_take = s.rd_take;
  assign o_cmd_valid = s.cmd_valid;
  assign o_cmd_code = s.cmd_code;
  assign o_wr_valid = s.wr_valid;
  assign o_wr_word = s.wr_word;
  assign o_crc_err = s.crc_err;
  assign o_ready = s.rdy;

  // ==========================================================
  // Checks
  logic [27:0] nr_cnt;
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nr_cnt <= '0;
    end else begin
      nr_cnt <= s.rdy ? 28'd0 : nr_cnt + 28'd1;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_n);

  a_addr_ack_match: assert property (
    $rose(s.oe) && $past(s.st) == ST_ADDR |-> $past(s.sh[7:1]) == `SIF_ADDR)
    else $error("address acknowledged without a match");
  a_cmd_two_bytes: assert property (
    o_cmd_valid |-> s.bpos == 3'd2 && o_cmd_code == {s.hi, s.sh})
    else $error("command code not built from two bytes");
  a_ready_bound: assert property (
    nr_cnt <= READY_CYC + 28'd3)
    else $error("not ready longer than the start-up delay");
  a_cmd_when_ready: assert property (
    o_cmd_valid |-> $past(s.rdy))
    else $error("command taken while not ready");
  a_reinit_drop: assert property (
    o_cmd_valid && o_cmd_code == `SIF_CMD_REINIT |-> ##2 !o_ready)
    else $error("reinit did not drop ready");
  a_wr_crc_check: assert property (
    o_wr_valid |-> o_crc_err == (sif_crc8(o_wr_word) != s.sh))
    else $error("checksum flag wrong");
  a_skip_released: assert property (
    s.st == ST_SKIP |-> !o_sda_oe)
    else $error("line driven while ignoring transfer");
  a_nack_busy: assert property (
    !s.rdy && s.st == ST_ADDR && fall && s.bc == 4'h8 |=> !o_sda_oe && s.st == ST_SKIP)
    else $error("address acknowledged while not ready");
  a_drive_low_only: assert property (
    o_sda_oe |-> !o_sda_o)
    else $error("data line driven high");

  c_reinit: cover property (o_cmd_valid && o_cmd_code == `SIF_CMD_REINIT);
  c_read_word: cover property (o_rd_take);
  c_crc_err: cover property (o_wr_valid && o_crc_err);

endmodule

`default_nettype wire

// ### sif_master.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Bus controller model, pulls lines low only
module sif_master (
  input wire logic i_core_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe
);
  initial begin
    o_scl_oe = 1'h0;
    o_sda_oe = 1'h0;
  end

  // Quarter of a 32 ns bus period; sped up to keep the run short
  task automatic q();
    repeat (2) @(posedge i_core_clk);
    #1;
  endtask

  task automatic start();
    o_sda_oe = 1'h1;
    q();
    q();
    o_scl_oe = 1'h1;
  endtask

  task automatic stop();
    q();
    o_sda_oe = 1'h1;
    q();
    o_scl_oe = 1'h0;
    q();
    o_sda_oe = 1'h0;
    q();
  endtask

  // Data moves mid-low so it never looks like a START or STOP
  task automatic bit_io(input logic b, output logic r);
    q();
    o_sda_oe = ~b;
    q();
    o_scl_oe = 1'h0;
    q();
    q();
    r = i_sda;
    o_scl_oe = 1'h1;
  endtask

  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r,
                      output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(a, k);
  endtask
endmodule

`default_nettype wire

// ### sif_top_tb.sv
`timescale 1ns/1ns
`default_nettype none

module sif_top_tb;
  // Short delay keeps the run small
  localparam int RDY = 200;
  typedef struct {
    logic [6:0] a;
    logic [15:0] cm;
    logic nw;
    logic [15:0] w;
    logic bad;
    logic ack;
  } sif_row_s;
  sif_row_s rows [6] = '{
    '{7'h62, 16'h21B1, 1'h0, 16'h0000, 1'h0, 1'h1},
    '{7'h62, 16'h241D, 1'h1, 16'h1234, 1'h0, 1'h1},
    '{7'h62, 16'h2427, 1'h1, 16'hFFFF, 1'h1, 1'h1},
    '{7'h63, 16'h21B1, 1'h0, 16'h0000, 1'h0, 1'h0},
    '{7'h22, 16'h241D, 1'h1, 16'h0001, 1'h0, 1'h0},
    '{7'h61, 16'h2427, 1'h1, 16'h8000, 1'h0, 1'h0}};
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic scl_oe, m_sda_oe, sda_o, sda_oe, scl, sda;
  logic [15:0] rd_word = 16'hBEEF;
  logic rd_take, cmd_valid, wr_valid, crc_err, ready;
  logic [15:0] cmd_code, wr_word;
  int fail_count = 0;
  int n_compared = 0;
  int n_cmd = 0;
  int n_wr = 0;
  int n_take = 0;
  int cyc = 0;
  int t_cmd = 0;
  int t_rdy = 0;
  logic rdy_q = 1'h0;

  // ==========================================================
  // Wiring
  assign scl = ~scl_oe;
  assign sda = ~(m_sda_oe | (sda_oe & ~sda_o));
  sif_top #(.READY_CYC(28'(RDY))) uut (.i_core_clk(clk), .i_arst_n(arst_n), .i_scl(scl),
    .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_rd_word(rd_word),
    .o_rd_take(rd_take), .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code),
    .o_wr_valid(wr_valid), .o_wr_word(wr_word), .o_crc_err(crc_err), .o_ready(ready));
  sif_master m (.i_core_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl_oe(scl_oe),
    .o_sda_oe(m_sda_oe));

  initial begin
    forever #2 clk = ~clk;
  end
  // Values seen here are those launched at the previous edge
  always @(posedge clk) begin
    cyc++;
    if (cmd_valid === 1'h1) begin
      n_cmd++;
      t_cmd = cyc;
    end
    if (wr_valid === 1'h1) n_wr++;
    // Fresh word after each take, so a stale second read shows up
    if (rd_take === 1'h1) begin
      n_take++;
      rd_word <= ~rd_word;
    end
    // Ready may rise in mid-transfer, so its edge is logged here
    if (ready === 1'h1 && rdy_q !== 1'h1) t_rdy = cyc;
    rdy_q = ready;
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'h1) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  // Written apart from the design on purpose
  function automatic logic [7:0] crc(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'h0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction

  task automatic wr(input sif_row_s r, output logic ak);
    logic [7:0] d;
    logic k;
    m.start();
    m.xfer({r.a, 1'h0}, 1'h1, d, k);
    ak = ~k;
    m.xfer(r.cm[15:8], 1'h1, d, k);
    m.xfer(r.cm[7:0], 1'h1, d, k);
    if (r.nw) begin
      m.xfer(r.w[15:8], 1'h1, d, k);
      m.xfer(r.w[7:0], 1'h1, d, k);
      m.xfer(crc(r.w) ^ {7'h00, r.bad}, 1'h1, d, k);
    end
    m.stop();
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic hard_reset(output int t0);
    #1 arst_n = 1'h0;
    repeat (20) @(posedge clk);
    chk({sda_oe, rd_take, cmd_valid, wr_valid, crc_err, ready} === 6'h00, "reset outputs");
    #1 arst_n = 1'h1;
    t0 = cyc;
  endtask

  task automatic wait_ready(input int t0, input string what);
    while (t_rdy <= t0 && cyc - t0 < RDY + 50) begin
      @(posedge clk);
      #1;
    end
    chk(t_rdy - t0 >= RDY && t_rdy - t0 <= RDY + 10, what);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #80000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end

  // ==========================================================
  // Tests
  initial begin
    logic ak;
    logic k;
    logic [7:0] b [6];
    int t0;
    int c0;
    int w0;
    hard_reset(t0);
    wr(rows[0], ak);
    chk(ak === 1'h0 && n_cmd == 0, "early command taken");
    wait_ready(t0, "power-up delay");
    $display("power-up test done");
    foreach (rows[i]) begin
      c0 = n_cmd;
      w0 = n_wr;
      wr(rows[i], ak);
      chk(ak === rows[i].ack, "address ack");
      chk(n_cmd - c0 == int'(rows[i].ack), "command strobe");
      if (rows[i].ack) chk(cmd_code === rows[i].cm, "command code");
      chk(n_wr - w0 == int'(rows[i].ack & rows[i].nw), "data strobe");
      if (rows[i].ack & rows[i].nw) chk(wr_word === rows[i].w, "data word");
      if (rows[i].ack & rows[i].nw) chk(crc_err === rows[i].bad, "checksum flag");
      $display("row %0d done", i);
    end
    c0 = n_take;
    m.start();
    m.xfer(8'hC5, 1'h1, b[0], k);
    chk(k === 1'h0, "read address ack");
    for (int i = 0; i < 6; i++) m.xfer(8'hFF, i == 5, b[i], k);
    m.stop();
    repeat (8) @(posedge clk);
    #1;
    chk({b[0], b[1], b[2]} === {16'hBEEF, crc(16'hBEEF)}, "first read word");
    chk({b[3], b[4], b[5]} === {16'h4110, crc(16'h4110)}, "second read word");
    chk(n_take - c0 == 2, "read takes");
    $display("read test done");
    // Controller sends a command during execution, expects no ack, then waits it out
    wr('{7'h62, 16'h3646, 1'h0, 16'h0000, 1'h0, 1'h1}, ak);
    chk(ak === 1'h1 && cmd_code === 16'h3646 && ready === 1'h0, "reinit");
    c0 = n_cmd;
    wr(rows[0], ak);
    chk(ak === 1'h0 && n_cmd == c0, "busy ack");
    wait_ready(t_cmd, "reinit delay");
    wr(rows[0], ak);
    chk(ak === 1'h1 && n_cmd == c0 + 1, "ready again");
    $display("reinit test done");
    hard_reset(t0);
    wait_ready(t0, "second power-up");
    $display("reset test done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
